// [isa_acq_assertions.sv]
// concurrent checks on the ports of the input sample acquisition block
`timescale 1ns/1ps
module isa_acq_checker
    import isa_pkg::*;
#(
    parameter int DIN_W = ISA_DIN_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [ISA_CH_W-1:0] mux_sel,
    input wire logic adc_convst,
    input wire logic adc_sclk,
    input wire logic link_fsync,
    input wire logic link_sclk,
    input wire logic ext_present,
    input wire logic bus_cs,
    input wire logic bus_rd,
    input wire logic [ISA_ADDR_W-1:0] bus_addr,
    input wire logic [DIN_W-1:0] bus_rdata,
    input wire logic bus_rvalid
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    AST_CONVST_ONE: assert property (adc_convst |=> !adc_convst)
        else $error("convert start longer than one cycle");
    AST_MUX_HELD: assert property (adc_convst |-> $stable(mux_sel)[*8])
        else $error("mux moved during conversion");
    AST_MUX_ACTIVE: assert property (mux_sel < 4'h6)
        else $error("mux outside active channels");
    AST_MUX_ORDER: assert property ($changed(mux_sel) |->
        (mux_sel == $past(mux_sel) + 4'h1) || (mux_sel == 4'h0))
        else $error("mux order broken");
    AST_FSYNC_ONE: assert property (link_fsync |=> !link_fsync)
        else $error("frame mark longer than one cycle");
    AST_SCLK_HIGH: assert property ($rose(link_sclk) |-> link_sclk[*4] ##1 !link_sclk)
        else $error("link bit clock high time wrong");
    AST_SCLK_SAME: assert property (adc_sclk == link_sclk)
        else $error("link clock differs from converter clock");
    AST_RVALID_LAT: assert property (bus_cs && bus_rd |=> bus_rvalid)
        else $error("read not answered next cycle");
    AST_RVALID_CAUSE: assert property (bus_rvalid |-> $past(bus_cs && bus_rd))
        else $error("answer without a read");
    AST_EXT_ABSENT: assert property (bus_cs && bus_rd && bus_addr == ISA_ADDR_DIN_EXT
        && !ext_present |=> bus_rdata == '0)
        else $error("absent extension read not zero");
endmodule

// [isa_input_sample_acquisition.sv]
// input sample acquisition: mux sequencing, sample pacing, serial link, digital inputs
`timescale 1ns/1ps
module isa_input_sample_acquisition
    import isa_pkg::*;
#(
    parameter int SETTLE_CYCLES = 8,
    parameter int DIN_W = ISA_DIN_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    // frequency tracking: processor-computed tick period in core_clk cycles
    input wire logic [ISA_PERIOD_W-1:0] track_period,
    input wire logic track_load,
    // multiplexer and converter
    output logic [ISA_CH_W-1:0] mux_sel,
    output logic adc_convst,
    input wire logic adc_busy,
    output logic adc_sclk,
    input wire logic adc_sdata,
    // dedicated sample link to processor serial port
    output logic link_fsync,
    output logic link_sclk,
    output logic link_sdata,
    output logic [ISA_CH_W-1:0] link_chan,
    // digital inputs
    input wire logic [DIN_W-1:0] din_main,
    input wire logic [DIN_W-1:0] din_ext,
    input wire logic ext_present,
    // parallel bus slave
    input wire logic bus_cs,
    input wire logic bus_rd,
    input wire logic [ISA_ADDR_W-1:0] bus_addr,
    output logic [DIN_W-1:0] bus_rdata,
    output logic bus_rvalid
);

    // ------------------------------------------------------------
    // synchronisers for pins
    // ------------------------------------------------------------
    logic busy_s1_reg, busy_s2_reg, sd_s1_reg, sd_s2_reg;
    logic [DIN_W-1:0] dm_s1_reg, dm_s2_reg, de_s1_reg, de_s2_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_s1_reg <= 1'b0;
            busy_s2_reg <= 1'b0;
            sd_s1_reg <= 1'b0;
            sd_s2_reg <= 1'b0;
            dm_s1_reg <= '0;
            dm_s2_reg <= '0;
            de_s1_reg <= '0;
            de_s2_reg <= '0;
        end else begin
            busy_s1_reg <= adc_busy;
            busy_s2_reg <= busy_s1_reg;
            sd_s1_reg <= adc_sdata;
            sd_s2_reg <= sd_s1_reg;
            dm_s1_reg <= din_main;
            dm_s2_reg <= dm_s1_reg;
            de_s1_reg <= din_ext;
            de_s2_reg <= de_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // sample pacing
    // ------------------------------------------------------------
    logic [ISA_PERIOD_W-1:0] period_reg, period_next;
    logic [ISA_PERIOD_W-1:0] tick_cnt_reg, tick_cnt_next;
    logic tick;

    always_comb begin
        period_next = period_reg;
        tick_cnt_next = tick_cnt_reg + 32'h1;
        tick = 1'b0;
        // zero or tiny periods would starve the scan, so they are ignored
        if (track_load && track_period > 32'h0000_0400) begin
            period_next = track_period;
        end
        if (tick_cnt_reg >= period_reg - 32'h1) begin
            tick_cnt_next = '0;
            tick = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_reg <= ISA_PERIOD_RESET;
            tick_cnt_reg <= '0;
        end else begin
            period_reg <= period_next;
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // scan and conversion
    // ------------------------------------------------------------
    function automatic logic [ISA_CH_W-1:0] isa_chan(input logic [ISA_CH_W-1:0] idx);
        // voltages first, then references, always in this order
        if (idx < ISA_CH_W'(ISA_NUM_VOLT)) begin
            return ISA_CH_VOLT0 + idx;
        end else begin
            return ISA_CH_REF0 + (idx - ISA_CH_W'(ISA_NUM_VOLT));
        end
    endfunction

    isa_state_t state_reg, state_next;
    logic [ISA_CH_W-1:0] idx_reg, idx_next;
    logic [ISA_CH_W-1:0] mux_reg, mux_next;
    logic [15:0] wait_reg, wait_next;
    logic [ISA_BIT_CNT_W-1:0] bit_reg, bit_next;
    logic [ISA_SCLK_CNT_W-1:0] div_reg, div_next;
    logic sclk_reg, sclk_next;
    logic conv_reg, conv_next;
    logic fsync_reg, fsync_next;
    logic sdo_reg, sdo_next;
    logic [ISA_CH_W-1:0] lchan_reg, lchan_next;
    logic pending_reg, pending_next;

    always_comb begin
        state_next = state_reg;
        idx_next = idx_reg;
        mux_next = mux_reg;
        wait_next = wait_reg;
        bit_next = bit_reg;
        div_next = div_reg;
        sclk_next = sclk_reg;
        conv_next = 1'b0;
        fsync_next = 1'b0;
        sdo_next = sdo_reg;
        lchan_next = lchan_reg;
        // a tick during a running scan is held so no sample instant is lost
        pending_next = pending_reg | tick;
        case (state_reg)
            ISA_IDLE: begin
                if (pending_reg) begin
                    pending_next = tick;
                    idx_next = '0;
                    mux_next = isa_chan('0);
                    wait_next = 16'(SETTLE_CYCLES);
                    state_next = ISA_SETTLE;
                end
            end
            ISA_SETTLE: begin
                wait_next = wait_reg - 16'h1;
                if (wait_reg == 16'h0) begin
                    conv_next = 1'b1;
                    wait_next = 16'h3;
                    state_next = ISA_CONV;
                end
            end
            ISA_CONV: begin
                // allow the busy flag to rise through the synchroniser
                if (wait_reg != 16'h0) begin
                    wait_next = wait_reg - 16'h1;
                end else if (!busy_s2_reg) begin
                    bit_next = '0;
                    div_next = '0;
                    sclk_next = 1'b0;
                    fsync_next = 1'b1;
                    lchan_next = mux_reg;
                    state_next = ISA_SHIFT;
                end
            end
            ISA_SHIFT: begin
                div_next = div_reg + ISA_SCLK_CNT_W'(1);
                if (div_reg == ISA_SCLK_CNT_W'(ISA_SCLK_HALF - 1)) begin
                    div_next = '0;
                    sclk_next = ~sclk_reg;
                    if (!sclk_reg) begin
                        // rising edge: converter bit passes straight to the link
                        sdo_next = sd_s2_reg;
                    end else begin
                        bit_next = bit_reg + ISA_BIT_CNT_W'(1);
                        if (bit_reg == ISA_BIT_CNT_W'(ISA_SAMPLE_W - 1)) begin
                            state_next = ISA_NEXT;
                        end
                    end
                end
            end
            ISA_NEXT: begin
                if (idx_reg == ISA_CH_W'(ISA_NUM_ACTIVE - 1)) begin
                    state_next = ISA_IDLE;
                end else begin
                    idx_next = idx_reg + ISA_CH_W'(1);
                    mux_next = isa_chan(idx_reg + ISA_CH_W'(1));
                    wait_next = 16'(SETTLE_CYCLES);
                    state_next = ISA_SETTLE;
                end
            end
            default: begin
                state_next = ISA_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ISA_IDLE;
            idx_reg <= '0;
            mux_reg <= ISA_CH_RESET;
            wait_reg <= '0;
            bit_reg <= '0;
            div_reg <= '0;
            sclk_reg <= 1'b0;
            conv_reg <= 1'b0;
            fsync_reg <= 1'b0;
            sdo_reg <= 1'b0;
            lchan_reg <= ISA_CH_RESET;
            pending_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            mux_reg <= mux_next;
            wait_reg <= wait_next;
            bit_reg <= bit_next;
            div_reg <= div_next;
            sclk_reg <= sclk_next;
            conv_reg <= conv_next;
            fsync_reg <= fsync_next;
            sdo_reg <= sdo_next;
            lchan_reg <= lchan_next;
            pending_reg <= pending_next;
        end
    end

    assign mux_sel = mux_reg;
    assign adc_convst = conv_reg;
    assign adc_sclk = sclk_reg;
    assign link_sclk = sclk_reg;
    assign link_fsync = fsync_reg;
    assign link_sdata = sdo_reg;
    assign link_chan = lchan_reg;

    // ------------------------------------------------------------
    // digital input filter and bus slave
    // ------------------------------------------------------------
    logic [DIN_W-1:0] fm_reg, fm_next, fe_reg, fe_next;
    logic [ISA_FILT_CNT_W-1:0] cm_reg [DIN_W];
    logic [ISA_FILT_CNT_W-1:0] cm_next [DIN_W];
    logic [ISA_FILT_CNT_W-1:0] ce_reg [DIN_W];
    logic [ISA_FILT_CNT_W-1:0] ce_next [DIN_W];
    logic [DIN_W-1:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;

    always_comb begin
        fm_next = fm_reg;
        fe_next = fe_reg;
        // a new level must hold for the full filter length to be accepted
        for (int i = 0; i < DIN_W; i++) begin
            cm_next[i] = (dm_s2_reg[i] == fm_reg[i]) ? '0 : cm_reg[i] + ISA_FILT_CNT_W'(1);
            if (cm_reg[i] == ISA_FILT_LEN) begin
                fm_next[i] = dm_s2_reg[i];
                cm_next[i] = '0;
            end
            ce_next[i] = (de_s2_reg[i] == fe_reg[i]) ? '0 : ce_reg[i] + ISA_FILT_CNT_W'(1);
            if (ce_reg[i] == ISA_FILT_LEN) begin
                fe_next[i] = de_s2_reg[i];
                ce_next[i] = '0;
            end
        end
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        // only answers processor reads, never drives transfers itself
        if (bus_cs && bus_rd) begin
            rvalid_next = 1'b1;
            if (bus_addr == ISA_ADDR_DIN_MAIN) begin
                rdata_next = fm_reg;
            end else if (bus_addr == ISA_ADDR_DIN_EXT && ext_present) begin
                rdata_next = fe_reg;
            end else begin
                rdata_next = '0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fm_reg <= ISA_DIN_RESET;
            fe_reg <= ISA_DIN_RESET;
            for (int i = 0; i < DIN_W; i++) begin
                cm_reg[i] <= '0;
                ce_reg[i] <= '0;
            end
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            fm_reg <= fm_next;
            fe_reg <= fe_next;
            for (int i = 0; i < DIN_W; i++) begin
                cm_reg[i] <= cm_next[i];
                ce_reg[i] <= ce_next[i];
            end
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign bus_rdata = rdata_reg;
    assign bus_rvalid = rvalid_reg;

endmodule

// [isa_partner_models.sv]
// converter model and processor serial port receiver
`timescale 1ns/1ps
module isa_adc_model
    import isa_pkg::*;
#(
    parameter int BUSY_CYC = 20
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [ISA_CH_W-1:0] mux_sel,
    input wire logic adc_convst,
    input wire logic adc_sclk,
    output logic adc_busy,
    output logic adc_sdata
);
    logic [15:0] word;
    logic sclk_q;
    int cnt;
    int bitn;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_busy <= 1'b0;
            adc_sdata <= 1'b0;
            sclk_q <= 1'b0;
            bitn <= 16;
            cnt <= 0;
        end else begin
            sclk_q <= adc_sclk;
            if (adc_convst) begin
                // one path for every channel: value names the mux position
                word <= {mux_sel, 4'h9, ~mux_sel, 4'h6};
                adc_busy <= 1'b1;
                cnt <= BUSY_CYC;
                bitn <= 0;
            end else if (cnt > 0) cnt <= cnt - 1;
            else adc_busy <= 1'b0;
            // msb first, 16 bits; next bit goes out as soon as the clock fall is seen
            if (sclk_q && !adc_sclk && bitn < 16) begin
                bitn <= bitn + 1;
                adc_sdata <= (bitn < 15) ? word[14 - bitn] : ~adc_sdata;
            end else begin
                // outside a word the line keeps toggling
                adc_sdata <= (bitn < 16) ? word[15 - bitn] : ~adc_sdata;
            end
        end
    end
endmodule
module isa_dsp_port
    import isa_pkg::*;
#(
    parameter logic [15:0] CAL_OFFSET = 16'h0000
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic link_fsync,
    input wire logic link_sclk,
    input wire logic link_sdata,
    input wire logic [ISA_CH_W-1:0] link_chan,
    output logic [15:0] rx_word,
    output logic [15:0] rx_cal,
    output logic [ISA_CH_W-1:0] rx_chan,
    output logic rx_done
);
    logic [15:0] sh;
    logic q;
    int n;
    // bits taken on the falling link clock, where the data has settled
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= 1'b0;
            rx_done <= 1'b0;
            n <= 16;
        end else begin
            q <= link_sclk;
            rx_done <= 1'b0;
            if (link_fsync) n <= 0;
            else if (q && !link_sclk && n < 16) begin
                sh <= {sh[14:0], link_sdata};
                n <= n + 1;
                if (n == 15) begin
                    rx_word <= {sh[14:0], link_sdata};
                    // correction is the processor's job; the link only carries raw words
                    rx_cal <= {sh[14:0], link_sdata} + CAL_OFFSET;
                    rx_chan <= link_chan;
                    rx_done <= 1'b1;
                end
            end
        end
    end
endmodule

// [isa_pkg.sv]
// package of constants for the input sample acquisition block
package isa_pkg;
    localparam int ISA_NUM_CHANNELS = 16;
    localparam int ISA_CH_W = 4;
    localparam int ISA_NUM_VOLT = 3;
    localparam int ISA_NUM_REF = 3;
    localparam int ISA_NUM_ACTIVE = ISA_NUM_VOLT + ISA_NUM_REF;
    localparam int ISA_SAMPLES_PER_CYCLE = 24;
    localparam int ISA_SAMPLE_W = 16;
    localparam int ISA_BIT_CNT_W = 5;
    localparam int ISA_DIN_W = 8;
    localparam int ISA_FILT_CNT_W = 4;
    localparam logic [ISA_FILT_CNT_W-1:0] ISA_FILT_LEN = 4'hF;
    localparam int ISA_CLK_MHZ = 100;
    localparam int ISA_SCLK_HALF = 4;
    localparam int ISA_SCLK_CNT_W = 3;
    localparam int ISA_PERIOD_W = 32;
    // default tick period: 50 Hz, 24 samples: 1/1200 s at 100 MHz
    localparam logic [ISA_PERIOD_W-1:0] ISA_PERIOD_RESET = 32'h0001_4585;
    localparam logic [ISA_CH_W-1:0] ISA_CH_VOLT0 = 4'h0;
    localparam logic [ISA_CH_W-1:0] ISA_CH_REF0 = 4'h3;
    localparam logic [ISA_CH_W-1:0] ISA_CH_RESET = 4'h0;
    localparam logic [ISA_DIN_W-1:0] ISA_DIN_RESET = 8'h00;
    localparam logic [7:0] ISA_ADDR_DIN_MAIN = 8'h00;
    localparam logic [7:0] ISA_ADDR_DIN_EXT = 8'h01;
    localparam int ISA_ADDR_W = 8;
    typedef enum logic [2:0] {
        ISA_IDLE, ISA_SETTLE, ISA_CONV, ISA_SHIFT, ISA_NEXT
    } isa_state_t;
endpackage

// [tb_isa_input_sample_acquisition.sv]
// testbench for the input sample acquisition block
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module tb_isa_input_sample_acquisition;
    import isa_pkg::*;
    logic core_clk, rst_n, track_load, adc_convst, adc_busy, adc_sclk, adc_sdata;
    logic link_fsync, link_sclk, link_sdata, ext_present, bus_cs, bus_rd, bus_rvalid, rx_done;
    logic [ISA_PERIOD_W-1:0] track_period;
    logic [3:0] mux_sel, link_chan, rx_chan;
    logic [7:0] din_main, din_ext, bus_addr, bus_rdata;
    logic [15:0] rx_word, rx_cal;
    // processor-side correction coefficient, value arbitrary
    localparam logic [15:0] CAL_OFS = 16'h0021;
    int errors = 0;
    int checks_done = 0;
    isa_input_sample_acquisition u_isa_input_sample_acquisition (.core_clk(core_clk),
        .rst_n(rst_n), .track_period(track_period), .track_load(track_load),
        .mux_sel(mux_sel), .adc_convst(adc_convst), .adc_busy(adc_busy), .adc_sclk(adc_sclk),
        .adc_sdata(adc_sdata), .link_fsync(link_fsync), .link_sclk(link_sclk),
        .link_sdata(link_sdata), .link_chan(link_chan), .din_main(din_main), .din_ext(din_ext),
        .ext_present(ext_present), .bus_cs(bus_cs), .bus_rd(bus_rd), .bus_addr(bus_addr),
        .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid));
    isa_adc_model u_isa_adc_model (.core_clk(core_clk), .rst_n(rst_n), .mux_sel(mux_sel),
        .adc_convst(adc_convst), .adc_sclk(adc_sclk), .adc_busy(adc_busy), .adc_sdata(adc_sdata));
    isa_dsp_port #(.CAL_OFFSET(CAL_OFS)) u_isa_dsp_port (.core_clk(core_clk), .rst_n(rst_n),
        .link_fsync(link_fsync), .link_sclk(link_sclk), .link_sdata(link_sdata),
        .link_chan(link_chan), .rx_word(rx_word), .rx_cal(rx_cal), .rx_chan(rx_chan),
        .rx_done(rx_done));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic results();
        if (errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic load(input logic [31:0] p);
        @(negedge core_clk);
        track_period = p;
        track_load = 1'b1;
        @(negedge core_clk);
        track_load = 1'b0;
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin @(negedge core_clk); n++; end while (rx_done !== 1'b1 && n < 4000);
        `CHK(rx_done, 1'b1)
    endtask
    // cycles from one scan start to the next must equal the loaded period
    task automatic span(input int p);
        int n, k;
        do wait_done(); while (rx_chan !== 4'h5);
        n = 0;
        do begin @(negedge core_clk); n++; end while (link_fsync !== 1'b1 && n < 5000);
        n = 0;
        k = 0;
        while (k < 6 && n < 20000) begin
            @(negedge core_clk);
            n++;
            if (link_fsync === 1'b1) k++;
        end
        `CHK(n, p)
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        bus_cs = 1'b1;
        bus_rd = 1'b1;
        bus_addr = a;
        @(negedge core_clk);
        // answer stands for the one cycle after the taking edge
        `CHK(bus_rvalid, 1'b1)
        `CHK(bus_rdata, exp)
        bus_cs = 1'b0;
        bus_rd = 1'b0;
    endtask
    task automatic t_scan();
        load(32'h0000_0500);
        for (int k = 0; k < 6; k++) begin
            wait_done();
            `CHK(rx_chan, 4'(k))
            `CHK(rx_word, {4'(k), 4'h9, ~4'(k), 4'h6})
            `CHK(rx_cal, 16'({4'(k), 4'h9, ~4'(k), 4'h6} + CAL_OFS))
        end
        span(32'h0000_0500);
    endtask
    task automatic t_rate();
        load(32'h0000_0600);
        span(32'h0000_0600);
        // at the guard value the load is ignored
        load(32'h0000_0400);
        span(32'h0000_0600);
    endtask
    task automatic t_din();
        @(negedge core_clk);
        din_main = 8'hA5;
        repeat (10) @(negedge core_clk);
        din_main = 8'h00;
        repeat (20) @(negedge core_clk);
        rd(ISA_ADDR_DIN_MAIN, 8'h00);
        din_main = 8'hA5;
        repeat (8) @(negedge core_clk);
        rd(ISA_ADDR_DIN_MAIN, 8'h00);
        repeat (20) @(negedge core_clk);
        rd(ISA_ADDR_DIN_MAIN, 8'hA5);
    endtask
    task automatic t_ext();
        din_ext = 8'h3C;
        repeat (30) @(negedge core_clk);
        rd(ISA_ADDR_DIN_EXT, 8'h00);
        ext_present = 1'b1;
        rd(ISA_ADDR_DIN_EXT, 8'h3C);
        rd(8'h02, 8'h00);
    endtask
    // ----------------------------------------
    // run
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #300000;
        errors++;
        results();
    end
    initial begin
        rst_n = 1'b0;
        track_load = 1'b0;
        track_period = 32'h0000_0000;
        din_main = 8'h00;
        din_ext = 8'h00;
        ext_present = 1'b0;
        bus_cs = 1'b0;
        bus_rd = 1'b0;
        bus_addr = 8'h00;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        t_scan();
        t_rate();
        t_din();
        t_ext();
        results();
    end
endmodule
bind isa_input_sample_acquisition isa_acq_checker #(.DIN_W(DIN_W)) u_isa_acq_checker (
    .core_clk(core_clk), .rst_n(rst_n), .mux_sel(mux_sel), .adc_convst(adc_convst),
    .adc_sclk(adc_sclk), .link_fsync(link_fsync), .link_sclk(link_sclk),
    .ext_present(ext_present), .bus_cs(bus_cs), .bus_rd(bus_rd), .bus_addr(bus_addr),
    .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid));
